// ---- rxtx_pkg.sv ----
// Package: register map, field layout and shared types of the receive status / undershoot block
package rxtx_pkg;

	// ************************************************
	// Register map
	// ************************************************
	localparam logic [6:0]  ADDR_RECV_STATUS   = 7'h13;
	localparam logic [6:0]  ADDR_TX_FALL_SHAPE = 7'h14;

	// ************************************************
	// Field positions and widths
	// ************************************************
	localparam int          COLL_POS_LSB   = 19;
	localparam int          COLL_POS_W     = 7;
	localparam int          COLL_SEEN_BIT  = 18;
	localparam int          FRAME_ERR_BIT  = 17;
	localparam int          CHECK_ERR_BIT  = 16;
	localparam int          LAST_BITS_LSB  = 13;
	localparam int          LAST_BITS_W    = 3;
	localparam int          FRAMES_LSB     = 9;
	localparam int          FRAMES_W       = 4;
	localparam int          BYTES_LSB      = 0;
	localparam int          BYTES_W        = 9;
	localparam int          PATTERN_LSB    = 16;
	localparam int          PATTERN_W      = 16;
	localparam int          SHAPE_LEN_LSB  = 1;
	localparam int          SHAPE_LEN_W    = 4;
	localparam int          SHAPE_EN_BIT   = 0;
	localparam int          ALIGN_W        = 3;

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [31:0] RST_RECV_STATUS = 32'h0000_0000;
	localparam logic [31:0] RST_FALL_SHAPE = 32'h0000_0000;
	localparam logic [3:0]  RST_COUNT4     = 4'h0;

	// ************************************************
	// Types
	// ************************************************
	typedef struct packed {
		logic [6:0] first_collision_position;
		logic       coll_seen;
		logic       framing_fault;
		logic       check_fault;
		logic [2:0] last_bits;
		logic [3:0] frames;
		logic [8:0] bytes;
	} rxtx_status_s;

	typedef struct packed {
		logic [15:0] pattern;
		logic [3:0]  falling_edge_shape_length;
		logic        falling_edge_shaping_on;
	} rxtx_shape_s;

	// Receiver events reported by the decoder, one-cycle pulses except levels noted
	typedef struct packed {
		logic       rx_start;      // Reception of a new frame begins
		logic       bit_valid;     // One data bit decoded
		logic       bit_coll;      // That data bit collided
		logic       byte_done;     // One data byte completed
		logic       proto_err;     // Stop bit / SOF / EOF / byte count fault
		logic       parity_err;
		logic       crc_err;
		logic       frame_end;     // Frame finished, with last_bits below
		logic [2:0] last_bits;
		logic       rx_done;       // Receive-done interrupt raised
	} rxtx_rx_ev_s;

	typedef enum logic [1:0] {
		RXTX_SH_IDLE,
		RXTX_SH_RUN
	} rxtx_shape_e;

endpackage : rxtx_pkg

// ---- rxtx_status_core.sv ----
// Receive status tracking: collision position, fault flags and counts
`timescale 1ns/100ps

module rxtx_status_core
	import rxtx_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire rxtx_rx_ev_s       i_ev,
	input  wire logic [2:0]        i_align,
	input  wire logic              i_coll_mode_ok,
	input  wire logic              i_rev_parity_stop,
	input  wire logic              i_multi_frame_receive_on,
	output logic                   o_stopped,
	output rxtx_status_s           o_status
);

	rxtx_status_s status_r;
	rxtx_status_s status_nxt;
	logic         stopped_r;
	logic         stopped_nxt;
	logic         pos_locked_r;
	logic         pos_locked_nxt;
	logic [6:0]   bit_cnt_r;
	logic [6:0]   bit_cnt_nxt;
	logic [8:0]   byte_cnt_r;
	logic [8:0]   byte_cnt_nxt;
	logic         live;

	always_comb
	begin
		status_nxt     = status_r;
		stopped_nxt    = stopped_r;
		pos_locked_nxt = pos_locked_r;
		bit_cnt_nxt    = bit_cnt_r;
		byte_cnt_nxt   = byte_cnt_r;
		live           = !stopped_r;
		if (i_ev.rx_start)
		begin
			status_nxt.framing_fault = 1'b0; // [R7]
			status_nxt.check_fault   = 1'b0; // [R7]
			stopped_nxt              = 1'b0;
			pos_locked_nxt           = 1'b0;
			// Position starts at the alignment offset [R3] [R16]
			bit_cnt_nxt              = {4'h0, i_align};
			byte_cnt_nxt             = 9'h000;
			live                     = 1'b1;
			if (!i_multi_frame_receive_on)
			begin
				status_nxt.coll_seen                = 1'b0;
				status_nxt.first_collision_position = 7'h00;
			end
		end
		if (live && i_ev.bit_valid)
		begin
			// Only data bits advance the position [R1]
			if (i_ev.bit_coll && !pos_locked_nxt)
			begin
				status_nxt.coll_seen = 1'b1; // [R4]
				pos_locked_nxt       = 1'b1;
				// Meaningful only in the collision-capable modes [R2]
				if (i_coll_mode_ok)
					status_nxt.first_collision_position = bit_cnt_nxt; // [R1]
			end
			bit_cnt_nxt = bit_cnt_nxt + 7'h01;
		end
		if (live && i_ev.byte_done)
			byte_cnt_nxt = byte_cnt_nxt + 9'h001;
		if (live && (i_ev.crc_err || (i_ev.parity_err && !i_rev_parity_stop)))
			status_nxt.check_fault = 1'b1; // [R8] [R9]
		if (live && i_ev.proto_err)
		begin
			status_nxt.framing_fault = 1'b1; // [R5]
			stopped_nxt              = 1'b1; // [R6]
		end
		if (live && i_ev.frame_end)
			status_nxt.last_bits = i_ev.last_bits; // [R10]
		if (i_ev.rx_done)
		begin
			// Counts are latched on receive-done and held until the next receive-done [R12]
			status_nxt.bytes = byte_cnt_nxt; // [R12]
			if (i_multi_frame_receive_on)
				status_nxt.frames = status_r.frames + 4'h1; // [R11]
			else
				status_nxt.frames = RST_COUNT4;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			status_r     <= rxtx_status_s'(RST_RECV_STATUS[25:0]);
			stopped_r    <= 1'b0;
			pos_locked_r <= 1'b0;
			bit_cnt_r    <= 7'h00;
			byte_cnt_r   <= 9'h000;
		end
		else
		begin
			status_r     <= status_nxt;
			stopped_r    <= stopped_nxt;
			pos_locked_r <= pos_locked_nxt;
			bit_cnt_r    <= bit_cnt_nxt;
			byte_cnt_r   <= byte_cnt_nxt;
		end
	end

	assign o_status  = status_r;
	assign o_stopped = stopped_r;

endmodule // rxtx_status_core

// ---- rxtx_shaper.sv ----
// Falling-edge undershoot shaping of the transmit modulation stream
`timescale 1ns/100ps

module rxtx_shaper
	import rxtx_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire rxtx_shape_s       i_cfg,
	input  wire logic              i_tx_mod,
	output logic                   o_tx_mod
);

	rxtx_shape_e state_r;
	rxtx_shape_e state_nxt;
	logic [3:0]  idx_r;
	logic [3:0]  idx_nxt;
	logic        prev_r;
	logic        out_r;
	logic        out_nxt;
	logic        fall;

	// Pattern bits replace the stream from the edge on, LSB first
	always_comb
	begin
		fall      = prev_r && !i_tx_mod;
		state_nxt = state_r;
		idx_nxt   = idx_r;
		out_nxt   = i_tx_mod;
		case (state_r)
			RXTX_SH_IDLE:
			begin
				if (fall && i_cfg.falling_edge_shaping_on) // [R13] [R15]
				begin
					out_nxt = i_cfg.pattern[0]; // [R14]
					idx_nxt = 4'h1;
					if (i_cfg.falling_edge_shape_length != 4'h0)
						state_nxt = RXTX_SH_RUN;
				end
			end
			RXTX_SH_RUN:
			begin
				if (!i_cfg.falling_edge_shaping_on) // [R15]
					state_nxt = RXTX_SH_IDLE;
				else
				begin
					// Length plus one bits in total, the rest ignored [R14]
					out_nxt = i_cfg.pattern[idx_r];
					idx_nxt = idx_r + 4'h1;
					if (idx_r >= i_cfg.falling_edge_shape_length)
						state_nxt = RXTX_SH_IDLE;
				end
			end
			default:
				state_nxt = RXTX_SH_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= RXTX_SH_IDLE;
			idx_r   <= 4'h0;
			prev_r  <= 1'b0;
			out_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			idx_r   <= idx_nxt;
			prev_r  <= i_tx_mod;
			out_r   <= out_nxt;
		end
	end

	assign o_tx_mod = out_r;

endmodule // rxtx_shaper

// ---- rxtx_regs.sv ----
// Top: receiver status and falling-edge shaping registers with their logic
//
// Notes on behaviour
// R1: Collision position counts data bits only.
// R2: Position meaningful only in collision-capable modes.
// R3: Nonzero receive alignment adds into position.
// R4: Collision sets collision-seen flag.
// R5: Protocol error sets framing-fault flag.
// R6: Protocol error stops reception of frame.
// R7: Next reception start clears both fault flags.
// R8: Parity or CRC mismatch sets check-fault.
// R9: Reversed-parity stop suppresses parity check-fault.
// R10: Valid bits of last byte reported.
// R11: Frame count updates on receive-done.
// R12: Byte count valid from done until restart.
// R13: Pattern follows each falling modulation edge that comes while no pattern is running.
// R14: Length plus one bits, LSB first.
// R15: Shaping only while enable bit set.
// R16: Alignment sets storage position of first bit.
// R17: Status reads have no side effects.
`timescale 1ns/100ps

module rxtx_regs
	import rxtx_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [6:0]        i_addr,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire logic [31:0]       i_wdata,
	output logic [31:0]            o_rdata,
	output logic                   o_rvalid,
	input  wire rxtx_rx_ev_s       i_rx_ev,
	input  wire logic [2:0]        i_align,
	input  wire logic              i_coll_mode_ok,
	input  wire logic              i_rev_parity_stop,
	input  wire logic              i_multi_frame_receive_on,
	output logic                   o_rx_stopped,
	input  wire logic              i_tx_mod,
	output logic                   o_tx_mod
);

	// ************************************************
	// Shaping configuration register
	// ************************************************
	rxtx_shape_s  shape_r;
	rxtx_shape_s  shape_nxt;
	logic [31:0]  rdata_r;
	logic [31:0]  rdata_nxt;
	logic         rvalid_r;
	rxtx_status_s status;

	always_comb
	begin
		shape_nxt = shape_r;
		if (i_wr && i_addr == ADDR_TX_FALL_SHAPE)
		begin
			shape_nxt.pattern                   = i_wdata[PATTERN_LSB +: PATTERN_W];
			shape_nxt.falling_edge_shape_length = i_wdata[SHAPE_LEN_LSB +: SHAPE_LEN_W];
			shape_nxt.falling_edge_shaping_on   = i_wdata[SHAPE_EN_BIT];
		end
	end

	// ************************************************
	// Read path
	// ************************************************
	// Reads only select data; status is never touched here [R17]
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (i_rd)
		begin
			case (i_addr)
				ADDR_RECV_STATUS:
					rdata_nxt = {6'h00, status};
				ADDR_TX_FALL_SHAPE:
					rdata_nxt = {shape_r.pattern, 11'h000,
						shape_r.falling_edge_shape_length,
						shape_r.falling_edge_shaping_on};
				default:
					rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			shape_r  <= rxtx_shape_s'(RST_FALL_SHAPE[20:0]);
			rdata_r  <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end
		else
		begin
			shape_r  <= shape_nxt;
			rdata_r  <= rdata_nxt;
			rvalid_r <= i_rd;
		end
	end

	assign o_rdata  = rdata_r;
	assign o_rvalid = rvalid_r;

	// ************************************************
	// Sub-blocks
	// ************************************************
	rxtx_status_core u_status (
		.i_clk                    (i_clk),
		.i_rst                    (i_rst),
		.i_ev                     (i_rx_ev),
		.i_align                  (i_align),
		.i_coll_mode_ok           (i_coll_mode_ok),
		.i_rev_parity_stop        (i_rev_parity_stop),
		.i_multi_frame_receive_on (i_multi_frame_receive_on),
		.o_stopped                (o_rx_stopped),
		.o_status                 (status)
	);

	rxtx_shaper u_shaper (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_cfg    (shape_r),
		.i_tx_mod (i_tx_mod),
		.o_tx_mod (o_tx_mod)
	);

endmodule // rxtx_regs

// ---- rxtx_props.sv ----
// Checker for register reads and receive stop behaviour
`timescale 1ns/100ps

module rxtx_props
	import rxtx_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [6:0]  i_addr,
	input  wire logic        i_rd,
	input  wire rxtx_rx_ev_s i_rx_ev,
	input  wire logic [31:0] o_rdata,
	input  wire logic        o_rvalid,
	input  wire logic        o_rx_stopped
);
	// ************************************************
	// Properties
	// ************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence rd_stat;
		i_rd && i_addr == ADDR_RECV_STATUS;
	endsequence
	// No event in the read cycle, so the next read sees the same word
	sequence rd_quiet;
		i_rd && i_addr == ADDR_RECV_STATUS && i_rx_ev == '0;
	endsequence

	rd_answer_a: assert property (i_rd |=> o_rvalid) else $error("read not answered");
	rd_spur_a: assert property (!i_rd |=> !o_rvalid) else $error("stray read valid");
	stat_rsvd_a: assert property (rd_stat |=> o_rdata[31:26] == 6'h00)
		else $error("status reserved bits set");
	shape_rsvd_a: assert property (i_rd && i_addr == ADDR_TX_FALL_SHAPE |=> o_rdata[15:5] == 11'h000)
		else $error("shaping reserved bits set");
	unmapped_zero_a: assert property (i_rd && !(i_addr inside {7'h13, 7'h14}) |=> o_rdata == '0)
		else $error("unmapped read not zero");
	proto_stop_a: assert property (i_rx_ev.proto_err && !i_rx_ev.rx_start |=> o_rx_stopped)
		else $error("reception not stopped");
	stop_hold_a: assert property (o_rx_stopped && !i_rx_ev.rx_start |=> o_rx_stopped)
		else $error("stop released early");
	start_clear_a: assert property (i_rx_ev.rx_start && !i_rx_ev.proto_err |=> !o_rx_stopped)
		else $error("stop not cleared at start");
	read_stable_a: assert property (rd_quiet ##1 rd_stat |=> $stable(o_rdata))
		else $error("status changed by a read");
endmodule // rxtx_props

bind rxtx_regs rxtx_props i_rxtx_props (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
	.i_rd(i_rd), .i_rx_ev(i_rx_ev), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
	.o_rx_stopped(o_rx_stopped));

// ---- rxtx_host.sv ----
// Host controller model driving the register access port
`timescale 1ns/100ps

module rxtx_host
	import rxtx_pkg::*;
(
	input  wire logic  i_clk,
	output logic [6:0] o_addr,
	output logic       o_wr,
	output logic       o_rd,
	output logic [31:0] o_wdata
);
	initial
	begin
		o_addr = 7'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 32'h0000_0000;
	end

	// One request per edge; callers chain them back to back, then idle
	task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wr <= w;
		o_rd <= !w;
		o_wdata <= d;
	endtask

	// Released lines show inverted values so stale data never looks valid
	task automatic idle();
		@(posedge i_clk);
		o_addr <= ~o_addr;
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_wdata <= ~o_wdata;
	endtask
endmodule // rxtx_host

// ---- testbench.sv ----
// Self-checking testbench for the receive status and shaping registers
`timescale 1ns/100ps

module testbench;
	import rxtx_pkg::*;
	localparam logic [11:0] START = 12'h800, BIT = 12'h400, COLL = 12'h200, BYTE = 12'h100;
	localparam logic [11:0] PROTO = 12'h080, PAR = 12'h040, CRC = 12'h020;
	localparam logic [11:0] FEND = 12'h016, DONE = 12'h001;
	logic        i_clk, i_rst, i_wr, i_rd, i_tx_mod, o_rvalid, o_rx_stopped, o_tx_mod;
	logic        i_coll_mode_ok, i_rev_parity_stop, i_multi_frame_receive_on;
	logic [6:0]  i_addr;
	logic [2:0]  i_align;
	logic [31:0] i_wdata, o_rdata, p, rnd = 32'h0000_0051;
	logic [6:0]  pos;
	rxtx_rx_ev_s ev;
	logic [31:0] q[$];
	int          error_cnt = 0, total_checks = 0, ci;

	rxtx_host i_rxtx_host (.i_clk(i_clk), .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd),
		.o_wdata(i_wdata));
	rxtx_regs i_rxtx_regs (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
		.i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rx_ev(ev),
		.i_align(i_align), .i_coll_mode_ok(i_coll_mode_ok), .i_rev_parity_stop(i_rev_parity_stop),
		.i_multi_frame_receive_on(i_multi_frame_receive_on), .o_rx_stopped(o_rx_stopped),
		.i_tx_mod(i_tx_mod), .o_tx_mod(o_tx_mod));

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction

	// Status word with two bytes and three valid last bits
	function automatic logic [31:0] st(input logic [6:0] ps, input logic [2:0] f, input logic [3:0] n);
		return {6'h00, ps, f, 3'h3, n, 9'h002};
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic close_out();
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic rd(input logic [6:0] a, input logic [31:0] e, input int n);
		repeat (n)
		begin
			q.push_back(e);
			i_rxtx_host.acc(1'b0, a, 32'h0000_0000);
		end
		i_rxtx_host.idle();
		repeat (2) @(posedge i_clk);
	endtask

	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		i_rxtx_host.acc(1'b1, a, d);
		i_rxtx_host.idle();
	endtask

	task automatic ev1(input logic [11:0] e);
		@(posedge i_clk);
		ev <= e;
	endtask

	task automatic frame(input logic [2:0] al, input int c, input logic [11:0] er,
		input logic [11:0] xt, input logic [31:0] ex);
		i_align <= al;
		ev1(START);
		for (int b = 0; b < 16; b++)
		begin
			ev1(BIT | ((b == c) ? COLL : 12'h000));
			if (b % 8 == 7)
				ev1(BYTE);
		end
		ev1(FEND);
		ev1(er);
		ev1(xt);
		ev1(DONE);
		ev1(12'h000);
		rd(ADDR_RECV_STATUS, ex, 2);
	endtask

	task automatic shape(input logic [31:0] c);
		wr(ADDR_TX_FALL_SHAPE, c);
		rd(ADDR_TX_FALL_SHAPE, c, 1);
		i_tx_mod <= 1'b0;
		@(posedge i_clk);
		for (int k = 0; k < 16; k++)
		begin
			@(negedge i_clk);
			chk(o_tx_mod, (c[0] && k <= c[4:1]) ? c[16 + k] : 1'b0);
		end
		@(posedge i_clk);
		i_tx_mod <= 1'b1;
		repeat (3) @(posedge i_clk);
	endtask

	// ************************************************
	// Clock, monitor, watchdog and sequence
	// ************************************************
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	always @(negedge i_clk)
		if (o_rvalid === 1'b1)
			chk(o_rdata, q.pop_front());

	initial
	begin
		#200000;
		error_cnt++;
		close_out();
	end

	initial
	begin
		i_rst = 1'b1;
		ev = '0;
		i_align = 3'h0;
		i_coll_mode_ok = 1'b1;
		i_rev_parity_stop = 1'b0;
		i_multi_frame_receive_on = 1'b0;
		i_tx_mod = 1'b1;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		wr(ADDR_RECV_STATUS, 32'hFFFF_FFFF);
		rd(ADDR_RECV_STATUS, 32'h0000_0000, 1);
		rd(7'h33, 32'h0000_0000, 1);
		for (int n = 0; n < 4; n++)
		begin
			p = xs();
			p[15:5] = 11'h000;
			p[0] = (n != 3);
			shape(p);
		end
		p = xs();
		ci = 5 + p[5:3];
		frame(p[2:0], ci, CRC, 12'h000, st(7'(ci + p[2:0]), 3'b101, 4'h0));
		i_rev_parity_stop <= 1'b1;
		frame(3'h0, -1, PAR, 12'h000, st(7'h00, 3'b000, 4'h0));
		i_rev_parity_stop <= 1'b0;
		frame(3'h0, -1, PROTO, BIT | COLL, st(7'h00, 3'b010, 4'h0));
		// Mode without collision position: flag still set, position left at zero
		i_coll_mode_ok <= 1'b0;
		frame(3'h2, 3, 12'h000, 12'h000, st(7'h00, 3'b100, 4'h0));
		i_coll_mode_ok <= 1'b1;
		i_multi_frame_receive_on <= 1'b1;
		p = xs();
		ci = 5 + p[5:3];
		pos = 7'(ci + p[2:0]);
		frame(p[2:0], ci, 12'h000, 12'h000, st(pos, 3'b100, 4'h1));
		frame(3'h0, -1, CRC, 12'h000, st(pos, 3'b101, 4'h2));
		repeat (4) @(posedge i_clk);
		close_out();
	end
endmodule // testbench
